// File: design/spt_pkg.sv
// constants, state encodings and carrier types shared by the servo pulse tester
package spt_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned UNIT_US = 10;
    localparam int unsigned CYCLES_10US = CLK_HZ / 1_000_000 * UNIT_US;
    localparam int unsigned POWERUP_MS = 200;
    localparam int unsigned POWERUP_CYCLES = CLK_HZ / 1000 * POWERUP_MS;
    localparam int unsigned INIT_WAIT_MS = 10;
    localparam int unsigned INIT_WAIT_CYCLES = CLK_HZ / 1000 * INIT_WAIT_MS;
    localparam int unsigned GAP_MS = 20;
    localparam int unsigned GAP_CYCLES = CLK_HZ / 1000 * GAP_MS;
    localparam int unsigned HOLD_MS = 500;
    localparam int unsigned HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
    localparam int unsigned TIMEOUT_UNITS = 65535;
    localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_UNITS * CYCLES_10US;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned SETUP_NS = 100;
    localparam int unsigned SETUP_CYCLES = CLK_HZ / 1_000_000 * SETUP_NS / 1000;
    localparam int unsigned STROBE_CYCLES = CYCLES_10US;
    localparam int unsigned SETTLE_MS = 2;
    localparam int unsigned SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;

    localparam logic [3:0] NIB_8BIT = 4'h3;
    localparam logic [3:0] NIB_4BIT = 4'h2;
    localparam logic [7:0] CMD_DISPLAY = 8'h0C;
    localparam logic [7:0] CMD_ENTRY = 8'h06;
    localparam logic [7:0] CMD_CLEAR = 8'h01;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] DEC_100 = 8'h64;
    localparam logic [7:0] DEC_10 = 8'h0A;
    localparam logic [1:0] INIT_REPEATS = 2'h3;
    localparam logic [1:0] DIGIT_LAST = 2'h2;

    localparam logic [7:0] SWEEP_MIN = 8'h64;
    localparam logic [7:0] SWEEP_MAX = 8'hC8;
    localparam logic [7:0] SWEEP_STEP = 8'h02;
    localparam logic [7:0] CENTRE_COUNT = 8'h96;
    localparam logic [15:0] UNITS_MAX = 16'hFFFF;

    localparam logic [4:0] TEXT_CYC_FIRST = 5'h00;
    localparam logic [4:0] TEXT_CYC_LAST = 5'h09;
    localparam logic [4:0] TEXT_PW_FIRST = 5'h0B;
    localparam logic [4:0] TEXT_PW_LAST = 5'h17;

    typedef struct packed {
        logic register_select_line;
        logic enable;
        logic [3:0] data;
    } spt_lcd_s;

    typedef enum logic [4:0] {
        ST_PWRUP = 5'h00,
        ST_INIT8 = 5'h01,
        ST_INIT8_WAIT = 5'h03,
        ST_INIT4 = 5'h02,
        ST_CMD_DISP = 5'h06,
        ST_CMD_ENTRY = 5'h07,
        ST_INIT_DONE = 5'h05,
        ST_CLR_CMD = 5'h04,
        ST_CLR_DONE = 5'h0C,
        ST_TEXT = 5'h0D,
        ST_MEAS_ARM = 5'h0F,
        ST_MEAS_HIGH = 5'h0E,
        ST_DIGITS = 5'h0A,
        ST_HOLD = 5'h0B,
        ST_GEN_HIGH = 5'h09,
        ST_GEN_GAP = 5'h08,
        ST_WAIT_WR = 5'h18
    } spt_state_e;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_SETUP = 2'h1,
        WR_HIGH = 2'h3,
        WR_LOW = 2'h2
    } spt_wr_e;

endpackage

// File: design/spt_debounce.sv
// button synchroniser and debouncer giving one pulse per press
`timescale 1ns/100ps
`default_nettype none
module spt_debounce #(
    parameter int unsigned STABLE_CYCLES = spt_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    output logic press
);
    import spt_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic stable;
        logic [31:0] cnt;
        logic press;
    } spt_deb_s;

    spt_deb_s st_ff;
    spt_deb_s nxt_st;

    if (STABLE_CYCLES < 1) begin : g_chk
        $error("spt_debounce: STABLE_CYCLES must be at least 1");
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.press = 1'b0;
        // level must hold unchanged for the whole window before it is believed
        if (st_ff.s2 != st_ff.stable) begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
            if (st_ff.cnt == 32'(STABLE_CYCLES - 1)) begin
                nxt_st.cnt = '0;
                nxt_st.stable = st_ff.s2;
                nxt_st.press = st_ff.s2;
            end
        end else begin
            nxt_st.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign press = st_ff.press;
endmodule
`default_nettype wire

// File: design/spt_lcd_writer.sv
// sends one nibble or one byte as two nibbles to the character display
`timescale 1ns/100ps
`default_nettype none
module spt_lcd_writer #(
    parameter int unsigned SETTLE_CYCLES = spt_pkg::SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic nibble_only,
    input wire logic rs,
    input wire logic [7:0] data,
    output logic done,
    output spt_pkg::spt_lcd_s lcd
);
    import spt_pkg::*;

    typedef struct packed {
        spt_wr_e st;
        logic second;
        logic [3:0] low_nib;
        logic [31:0] cnt;
        logic done;
        spt_lcd_s lcd;
    } spt_wr_s;

    spt_wr_s st_ff;
    spt_wr_s nxt_st;

    if (SETTLE_CYCLES < 1 || SETUP_CYCLES < 1) begin : g_chk
        $error("spt_lcd_writer: timing counts must be at least 1");
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.cnt = st_ff.cnt + 32'h1;
        case (st_ff.st)
            WR_IDLE: begin
                nxt_st.cnt = '0;
                if (go) begin
                    nxt_st.lcd.register_select_line = rs;
                    nxt_st.lcd.data = nibble_only ? data[3:0] : data[7:4];
                    nxt_st.low_nib = data[3:0];
                    nxt_st.second = !nibble_only;
                    nxt_st.st = WR_SETUP;
                end
            end
            WR_SETUP: begin
                if (st_ff.cnt == 32'(SETUP_CYCLES - 1)) begin
                    nxt_st.cnt = '0;
                    nxt_st.lcd.enable = 1'b1;
                    nxt_st.st = WR_HIGH;
                end
            end
            WR_HIGH: begin
                if (st_ff.cnt == 32'(STROBE_CYCLES - 1)) begin
                    nxt_st.cnt = '0;
                    nxt_st.lcd.enable = 1'b0;
                    nxt_st.st = WR_LOW;
                end
            end
            WR_LOW: begin
                // settle is long enough for the slow clear instruction too
                if (st_ff.cnt == 32'(SETTLE_CYCLES - 1)) begin
                    nxt_st.cnt = '0;
                    if (st_ff.second) begin
                        nxt_st.second = 1'b0;
                        nxt_st.lcd.data = st_ff.low_nib;
                        nxt_st.st = WR_SETUP;
                    end else begin
                        nxt_st.done = 1'b1;
                        nxt_st.st = WR_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.st = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;
    assign lcd = st_ff.lcd;
endmodule
`default_nettype wire

// File: design/spt_servo_tester.sv
// servo pulse tester top: pulse measurement, sweep generation, display driver
// Contract
// - generation mode drives a positive pulse between 1 and 2 ms wide
// - positioning pulses repeat at roughly fifty per second
// - a 20 ms gap follows every generated pulse
// - a width of 1.5 ms is the centre-of-travel command
// - generated width is a count of 10 us units
// - centring emits count 150 repeatedly, each followed by the gap
// - measurement and generation modes; each button press toggles the mode; code merges presses made before a pending toggle is served into one
// - measurement mode shows width in 10 us units, 1.5 ms shows 150
// - generation width sweeps repeatedly from 1 ms to 2 ms
// - measured and generated widths resolve exactly 10 us per count
// - shown value is 8-bit count as three decimal ASCII digits, 000 to 255
// - each digit gets 48 added after division and remainder
// - status strings sit at the lowest text addresses and are read from there
// - after power-up clear outputs and wait 200 ms before display setup
// - send nibble 0011 with three strobes, 10 ms wait after the first
// - then nibble 0010 with three strobes for the 4-bit interface
// - then instruction bytes 12 and 6, then register select goes high
// - bytes go high nibble then low nibble, each strobed, select kept
// - clear: select low, instruction byte 1, select high again
// - select low addresses instructions, high addresses character data
// - missing edge or pulse over 0.65535 s gives a result of zero
`timescale 1ns/100ps
`default_nettype none
module spt_servo_tester #(
    parameter int unsigned POWERUP_CYCLES = spt_pkg::POWERUP_CYCLES,
    parameter int unsigned INIT_WAIT_CYCLES = spt_pkg::INIT_WAIT_CYCLES,
    parameter int unsigned GAP_CYCLES = spt_pkg::GAP_CYCLES,
    parameter int unsigned HOLD_CYCLES = spt_pkg::HOLD_CYCLES,
    parameter int unsigned TIMEOUT_CYCLES = spt_pkg::TIMEOUT_CYCLES,
    parameter int unsigned SETTLE_CYCLES = spt_pkg::SETTLE_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = spt_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pulse_in,
    input wire logic button_in,
    input wire logic centre_hold,
    output logic servo_out,
    output spt_pkg::spt_lcd_s lcd,
    output logic mode_generate,
    output logic [7:0] measured_width
);
    import spt_pkg::*;

    // status strings, cycling text first, then the measurement label
    localparam logic [7:0] TEXT_ROM [0:23] = '{
        8'h43, 8'h79, 8'h63, 8'h6C, 8'h69, 8'h6E, 8'h67, 8'h2E,
        8'h2E, 8'h2E, 8'h20, 8'h50, 8'h75, 8'h6C, 8'h73, 8'h65,
        8'h20, 8'h57, 8'h69, 8'h64, 8'h74, 8'h68, 8'h3A, 8'h20
    };

    typedef struct packed {
        spt_state_e st;
        spt_state_e ret;
        logic mode_gen;
        logic toggle_req;
        logic rs;
        logic [31:0] cnt;
        logic [4:0] idx;
        logic [1:0] rep;
        logic [7:0] width;
        logic [15:0] units;
        logic [15:0] sub;
        logic armed;
        logic [7:0] shown;
        logic servo;
        logic wr_go;
        logic wr_nib;
        logic [7:0] wr_byte;
        logic pin_s1;
        logic pin_s2;
        logic hold_s1;
        logic hold_s2;
    } spt_main_s;

    spt_main_s st_ff;
    spt_main_s nxt_st;
    logic press;
    logic wr_done;

    if (POWERUP_CYCLES < 1 || INIT_WAIT_CYCLES < 1 || GAP_CYCLES < 1 || HOLD_CYCLES < 1 ||
        TIMEOUT_CYCLES < 1 || CYCLES_10US < 2) begin : g_chk
        $error("spt_servo_tester: timing counts out of range");
    end

    spt_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk(clk),
        .resetn(resetn),
        .pin(button_in),
        .press(press)
    );

    spt_lcd_writer #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_writer (
        .clk(clk),
        .resetn(resetn),
        .go(st_ff.wr_go),
        .nibble_only(st_ff.wr_nib),
        .rs(st_ff.rs),
        .data(st_ff.wr_byte),
        .done(wr_done),
        .lcd(lcd)
    );

    function automatic logic [7:0] ascii_digit(input logic [7:0] v, input logic [1:0] pos);
        logic [7:0] huns;
        logic [7:0] rest;
        logic [7:0] d;
        huns = v / DEC_100;
        rest = v % DEC_100;
        case (pos)
            2'h0: d = huns;
            2'h1: d = rest / DEC_10;
            default: d = rest % DEC_10;
        endcase
        return d + ASCII_ZERO;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pin_s1 = pulse_in;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.hold_s1 = centre_hold;
        nxt_st.hold_s2 = st_ff.hold_s1;
        nxt_st.wr_go = 1'b0;
        nxt_st.cnt = st_ff.cnt + 32'h1;
        case (st_ff.st)
            ST_PWRUP: begin
                if (st_ff.cnt == 32'(POWERUP_CYCLES - 1)) begin
                    nxt_st.rep = '0;
                    nxt_st.st = ST_INIT8;
                end
            end
            ST_INIT8: begin
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b1;
                nxt_st.wr_byte = {4'h0, NIB_8BIT};
                nxt_st.rep = st_ff.rep + 2'h1;
                if (st_ff.rep == 2'h0) begin
                    nxt_st.ret = ST_INIT8_WAIT;
                end else if (st_ff.rep == INIT_REPEATS - 2'h1) begin
                    nxt_st.rep = '0;
                    nxt_st.ret = ST_INIT4;
                end else begin
                    nxt_st.ret = ST_INIT8;
                end
                nxt_st.st = ST_WAIT_WR;
            end
            ST_INIT8_WAIT: begin
                if (st_ff.cnt == 32'(INIT_WAIT_CYCLES - 1)) begin
                    nxt_st.st = ST_INIT8;
                end
            end
            ST_INIT4: begin
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b1;
                nxt_st.wr_byte = {4'h0, NIB_4BIT};
                nxt_st.rep = st_ff.rep + 2'h1;
                nxt_st.ret = ST_INIT4;
                if (st_ff.rep == INIT_REPEATS - 2'h1) begin
                    nxt_st.rep = '0;
                    nxt_st.ret = ST_CMD_DISP;
                end
                nxt_st.st = ST_WAIT_WR;
            end
            ST_CMD_DISP: begin
                nxt_st.rs = 1'b0;
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b0;
                nxt_st.wr_byte = CMD_DISPLAY;
                nxt_st.ret = ST_CMD_ENTRY;
                nxt_st.st = ST_WAIT_WR;
            end
            ST_CMD_ENTRY: begin
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b0;
                nxt_st.wr_byte = CMD_ENTRY;
                nxt_st.ret = ST_INIT_DONE;
                nxt_st.st = ST_WAIT_WR;
            end
            ST_INIT_DONE: begin
                nxt_st.rs = 1'b1;
                nxt_st.st = ST_CLR_CMD;
            end
            ST_CLR_CMD: begin
                nxt_st.rs = 1'b0;
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b0;
                nxt_st.wr_byte = CMD_CLEAR;
                nxt_st.ret = ST_CLR_DONE;
                nxt_st.st = ST_WAIT_WR;
            end
            ST_CLR_DONE: begin
                nxt_st.rs = 1'b1;
                nxt_st.idx = st_ff.mode_gen ? TEXT_CYC_FIRST : TEXT_PW_FIRST;
                nxt_st.width = st_ff.hold_s2 ? CENTRE_COUNT : SWEEP_MIN;
                nxt_st.st = ST_TEXT;
            end
            ST_TEXT: begin
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b0;
                nxt_st.wr_byte = TEXT_ROM[st_ff.idx];
                nxt_st.idx = st_ff.idx + 5'h1;
                nxt_st.ret = ST_TEXT;
                if (st_ff.mode_gen && st_ff.idx == TEXT_CYC_LAST) begin
                    nxt_st.ret = ST_GEN_HIGH;
                end else if (!st_ff.mode_gen && st_ff.idx == TEXT_PW_LAST) begin
                    nxt_st.ret = ST_MEAS_ARM;
                end
                nxt_st.armed = 1'b0;
                nxt_st.st = ST_WAIT_WR;
            end
            ST_WAIT_WR: begin
                nxt_st.cnt = '0;
                if (wr_done) begin
                    nxt_st.st = st_ff.ret;
                end
            end
            ST_MEAS_ARM: begin
                // a pulse already high on entry is skipped: only a fresh rising edge starts timing
                if (!st_ff.pin_s2) begin
                    nxt_st.armed = 1'b1;
                end
                if (st_ff.armed && st_ff.pin_s2) begin
                    nxt_st.cnt = '0;
                    nxt_st.sub = 16'h1; // the edge cycle itself is already part of the pulse
                    nxt_st.units = '0;
                    nxt_st.st = ST_MEAS_HIGH;
                end else if (st_ff.cnt == 32'(TIMEOUT_CYCLES - 1)) begin
                    nxt_st.shown = '0;
                    nxt_st.idx = '0;
                    nxt_st.st = ST_DIGITS;
                end
            end
            ST_MEAS_HIGH: begin
                nxt_st.sub = st_ff.sub + 16'h1;
                if (!st_ff.pin_s2) begin
                    nxt_st.shown = st_ff.units[7:0];
                    nxt_st.idx = '0;
                    nxt_st.st = ST_DIGITS;
                end else if (st_ff.sub == 16'(CYCLES_10US - 1)) begin
                    nxt_st.sub = '0;
                    if (st_ff.units == UNITS_MAX) begin
                        nxt_st.shown = '0;
                        nxt_st.idx = '0;
                        nxt_st.st = ST_DIGITS;
                    end else begin
                        nxt_st.units = st_ff.units + 16'h1;
                    end
                end
            end
            ST_DIGITS: begin
                nxt_st.wr_go = 1'b1;
                nxt_st.wr_nib = 1'b0;
                nxt_st.wr_byte = ascii_digit(st_ff.shown, st_ff.idx[1:0]);
                nxt_st.idx = st_ff.idx + 5'h1;
                nxt_st.ret = (st_ff.idx[1:0] == DIGIT_LAST) ? ST_HOLD : ST_DIGITS;
                nxt_st.st = ST_WAIT_WR;
            end
            ST_HOLD: begin
                if (st_ff.cnt == 32'(HOLD_CYCLES - 1)) begin
                    if (st_ff.toggle_req) begin
                        nxt_st.mode_gen = !st_ff.mode_gen;
                        nxt_st.toggle_req = 1'b0;
                    end
                    nxt_st.st = ST_CLR_CMD;
                end
            end
            ST_GEN_HIGH: begin
                nxt_st.servo = 1'b1;
                if (st_ff.cnt == 32'(st_ff.width) * 32'(CYCLES_10US)) begin // first cycle here is still low
                    nxt_st.servo = 1'b0;
                    nxt_st.cnt = '0;
                    nxt_st.st = ST_GEN_GAP;
                end
            end
            ST_GEN_GAP: begin
                if (st_ff.cnt == 32'(GAP_CYCLES - 1)) begin
                    nxt_st.cnt = '0;
                    if (st_ff.hold_s2) begin
                        nxt_st.width = CENTRE_COUNT;
                    end else if (st_ff.width + SWEEP_STEP > SWEEP_MAX || st_ff.width < SWEEP_MIN) begin
                        nxt_st.width = SWEEP_MIN;
                    end else begin
                        nxt_st.width = st_ff.width + SWEEP_STEP;
                    end
                    nxt_st.st = ST_GEN_HIGH;
                    if (st_ff.toggle_req) begin
                        nxt_st.mode_gen = !st_ff.mode_gen;
                        nxt_st.toggle_req = 1'b0;
                        nxt_st.st = ST_CLR_CMD;
                    end
                end
            end
            default: begin
                nxt_st.st = ST_PWRUP;
            end
        endcase
        // a press in the same cycle as the clear is kept
        if (press) begin
            nxt_st.toggle_req = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign servo_out = st_ff.servo;
    assign mode_generate = st_ff.mode_gen;
    assign measured_width = st_ff.shown;
endmodule
`default_nettype wire

// File: test/spt_servo_tester_assertions.sv
// port-level checker for the servo pulse tester
`timescale 1ns/100ps
`default_nettype none
module spt_servo_tester_chk
    import spt_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = 50,
    parameter int unsigned GAP_CYCLES = 50
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic servo_out,
    input wire spt_pkg::spt_lcd_s lcd,
    input wire logic mode_generate
);
    logic [31:0] up_ff;
    logic [31:0] en_ff;
    logic [31:0] hi_ff;
    logic [31:0] lo_ff;
    // low count saturates so a long idle never wraps into a short gap
    always_ff @(posedge clk) begin
        if (!resetn) begin
            up_ff <= '0;
            en_ff <= '0;
            hi_ff <= '0;
            lo_ff <= '0;
        end else begin
            up_ff <= (up_ff == '1) ? up_ff : up_ff + 32'h1;
            en_ff <= lcd.enable ? en_ff + 32'h1 : '0;
            hi_ff <= servo_out ? hi_ff + 32'h1 : '0;
            lo_ff <= servo_out ? '0 : ((lo_ff == '1) ? lo_ff : lo_ff + 32'h1);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_en_rise;
        $rose(lcd.enable);
    endsequence
    sequence s_en_fall;
        $fell(lcd.enable);
    endsequence
    AST_RESET_OUT: assert property (@(posedge clk) disable iff (1'b0)
        !resetn |=> !servo_out && lcd == '0 && !mode_generate) else $error("outputs not cleared in reset");
    AST_POWERUP_WAIT: assert property (lcd.enable |-> up_ff >= POWERUP_CYCLES)
        else $error("strobe before power-up wait");
    AST_STROBE_LEN: assert property (s_en_fall |-> en_ff == 32'd1000)
        else $error("strobe length wrong");
    AST_SETUP: assert property (s_en_rise |-> $past(lcd.data, 5) == lcd.data
        && $past(lcd.register_select_line, 5) == lcd.register_select_line) else $error("no setup before strobe");
    AST_HOLD_HIGH: assert property (lcd.enable && $past(lcd.enable) |-> $stable(lcd.data)
        && $stable(lcd.register_select_line)) else $error("display lines moved in strobe");
    AST_SETTLE: assert property (s_en_fall |=> (!lcd.enable && $stable(lcd.data))[*8])
        else $error("display data moved after strobe");
    AST_SERVO_MEAS: assert property (!mode_generate |-> !servo_out)
        else $error("servo pulse in measurement mode");
    AST_GEN_WIDTH: assert property ($fell(servo_out) |-> hi_ff >= 32'd100000
        && hi_ff <= 32'd200000 && hi_ff % 32'd1000 == '0) else $error("servo pulse width wrong");
    AST_GAP: assert property ($rose(servo_out) |-> lo_ff >= GAP_CYCLES)
        else $error("gap between servo pulses too short");
endmodule
bind spt_servo_tester spt_servo_tester_chk #(
    .POWERUP_CYCLES(POWERUP_CYCLES),
    .GAP_CYCLES(GAP_CYCLES)
) i_chk (
    .clk(clk),
    .resetn(resetn),
    .servo_out(servo_out),
    .lcd(lcd),
    .mode_generate(mode_generate)
);
`default_nettype wire

// File: test/spt_servo_rx.sv
// behavioural receiver output sending servo pulses to the tester
`timescale 1ns/100ps
`default_nettype none
module spt_servo_rx #(
    parameter int unsigned HIGH_CYCLES = 5000,
    parameter int unsigned LOW_CYCLES = 3000
) (
    input wire logic clk,
    input wire logic resetn,
    output logic pulse
);
    int unsigned cnt;
    // runs free like a real receiver, so the tester may arm in mid-pulse
    always @(posedge clk) begin
        if (!resetn) begin
            cnt <= 0;
            pulse <= 1'b0;
        end else begin
            cnt <= (cnt == HIGH_CYCLES + LOW_CYCLES - 1) ? 0 : cnt + 1;
            pulse <= (cnt == HIGH_CYCLES + LOW_CYCLES - 1) || (cnt + 1 < HIGH_CYCLES);
        end
    end
endmodule
`default_nettype wire

// File: test/spt_servo_tester_tb.sv
// self-checking bench for the servo pulse tester
`timescale 1ns/100ps
`default_nettype none
module spt_servo_tester_tb;
    import spt_pkg::*;
    logic clk;
    logic resetn;
    logic pulse_in;
    logic button_in;
    logic centre_hold;
    logic servo_out;
    logic mode_generate;
    logic [7:0] measured_width;
    spt_lcd_s lcd;
    int bad_count;
    int total_checks;
    logic [4:0] nib_q[$];
    logic prev_en;

    // shortened waits keep the run short; the 10 us unit and the strobe stay full length
    localparam int unsigned T_PWR = 50, T_INIT = 20, T_GAP = 50, T_HOLD = 50, T_TMO = 20000, T_SET = 20, T_DEB = 8;
    localparam int unsigned RX_HIGH = 5000, RX_LOW = 3000;

    spt_servo_tester #(.POWERUP_CYCLES(T_PWR), .INIT_WAIT_CYCLES(T_INIT), .GAP_CYCLES(T_GAP), .HOLD_CYCLES(T_HOLD),
        .TIMEOUT_CYCLES(T_TMO), .SETTLE_CYCLES(T_SET), .DEBOUNCE_CYCLES(T_DEB)) i_dut (
        .clk(clk),
        .resetn(resetn),
        .pulse_in(pulse_in),
        .button_in(button_in),
        .centre_hold(centre_hold),
        .servo_out(servo_out),
        .lcd(lcd),
        .mode_generate(mode_generate),
        .measured_width(measured_width)
    );
    // 5000 cycles high is five 10 us units
    spt_servo_rx #(.HIGH_CYCLES(RX_HIGH), .LOW_CYCLES(RX_LOW)) i_rx (
        .clk(clk),
        .resetn(resetn),
        .pulse(pulse_in)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        prev_en <= lcd.enable;
        if (lcd.enable && !prev_en) nib_q.push_back({lcd.register_select_line, lcd.data});
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic get_nib(output logic [4:0] n);
        for (int i = 0; i < 60000 && nib_q.size() == 0; i++) @(posedge clk);
        n = (nib_q.size() == 0) ? 5'bx : nib_q.pop_front();
    endtask
    task automatic get_byte(logic rs, logic [7:0] exp, string what);
        logic [4:0] hi;
        logic [4:0] lo;
        get_nib(hi);
        get_nib(lo);
        check({what, " select"}, {14'h0, hi[4], lo[4]}, {14'h0, rs, rs});
        check(what, {8'h00, hi[3:0], lo[3:0]}, {8'h00, exp});
    endtask
    task automatic get_text(string s);
        for (int i = 0; i < s.len(); i++) get_byte(1'b1, s[i], "char");
    endtask

    task automatic test_init;
        logic [4:0] n;
        for (int i = 0; i < 6; i++) begin
            get_nib(n);
            check("init nibble", {11'h0, n}, (i < 3) ? 16'h0003 : 16'h0002);
        end
        get_byte(1'b0, 8'h0C, "display cmd");
        get_byte(1'b0, 8'h06, "entry cmd");
        $display("test_init done");
    endtask
    task automatic test_measure;
        get_byte(1'b0, 8'h01, "clear");
        get_text("Pulse Width: ");
        get_text("005");
        check("width", {8'h00, measured_width}, 16'h0005);
        $display("test_measure done");
    endtask
    task automatic test_toggle;
        int i;
        // a short bounce ahead of the press must not make a second toggle
        button_in <= 1'b1;
        repeat (2) @(posedge clk);
        button_in <= 1'b0;
        @(posedge clk);
        button_in <= 1'b1;
        repeat (30) @(posedge clk);
        button_in <= 1'b0;
        for (i = 0; i < 3000 && mode_generate !== 1'b1; i++) @(posedge clk);
        check("mode", {15'h0, mode_generate}, 16'h0001);
        get_byte(1'b0, 8'h01, "clear");
        get_text("Cycling...");
        for (i = 0; i < 3000 && servo_out !== 1'b1; i++) @(posedge clk);
        repeat (10000) @(posedge clk);
        check("servo high", {15'h0, servo_out}, 16'h0001);
        check("mode held", {15'h0, mode_generate}, 16'h0001);
        $display("test_toggle done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        button_in = 1'b0;
        centre_hold = 1'b0;
        prev_en = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        test_init();
        test_measure();
        test_toggle();
        stop_test();
    end
    initial begin
        // a clean run needs about 84000 cycles
        repeat (120000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire
